// >>> verilog/nvm_defs.svh
// constants for the data eeprom unlock and program block
`ifndef NVM_DEFS_SVH
`define NVM_DEFS_SVH

// ============================================================
// register byte offsets
`define NVM_KEY_OFS      8'h00
`define NVM_CTRL_OFS     8'h04
`define NVM_ADDR_OFS     8'h08
`define NVM_LATCH_OFS    8'h0C
`define NVM_STATUS_OFS   8'h10
`define NVM_RDATA_OFS    8'h14

// ============================================================
// unlock key values
`define NVM_KEY_FIRST    8'h55
`define NVM_KEY_SECOND   8'hAA

// ============================================================
// control register fields
`define NVM_CTRL_GO_BIT    15
`define NVM_CTRL_WREN_BIT  14
`define NVM_CTRL_PONLY_BIT 12
`define NVM_CTRL_WMASK     16'h507F
`define NVM_CTRL_RESET     16'h0000
`define NVM_OPSEL_BULK     6'h10
`define NVM_OPSEL_PROG     4'h1
`define NVM_CTRL_WERASE    13'h0004

// ============================================================
// status register fields
`define NVM_STAT_DONE_BIT  0
`define NVM_STAT_BUSY_BIT  1

// ============================================================
// array geometry and reset values
`define NVM_WORDS        256
`define NVM_WIDTH        16
`define NVM_ERASED       16'hFFFF
`define NVM_ZERO16       16'h0000

// ============================================================
// bus answers
`define AXI_RESP_OKAY    2'b00
`define AXI_RESP_SLVERR  2'b10

// ============================================================
// timing
`define NVM_CLK_PERIOD_NS 8
`define NVM_OP_TIME_NS    4000
`define NVM_OP_CYCLES \
    ((`NVM_OP_TIME_NS + `NVM_CLK_PERIOD_NS - 1) / `NVM_CLK_PERIOD_NS)

`endif

// >>> verilog/nvm_pkg.sv
// types shared by the data eeprom unlock and program block
package nvm_pkg;

    // ============================================================
    // unlock detector states
    typedef enum logic [2:0]
    {
        UL_IDLE  = 3'b001,
        UL_GOT55 = 3'b010,
        UL_OPEN  = 3'b100
    } unlock_state_t;

    // ============================================================
    // operation sequencer states
    typedef enum logic [1:0]
    {
        OP_IDLE = 2'b01,
        OP_BUSY = 2'b10
    } op_state_t;

    // ============================================================
    // operation kinds
    typedef enum logic [1:0]
    {
        KIND_NONE   = 2'h0,
        KIND_BULK   = 2'h1,
        KIND_WERASE = 2'h2,
        KIND_PROG   = 2'h3
    } op_kind_t;

endpackage : nvm_pkg

// >>> verilog/eeprom_array.sv
// data eeprom word storage with erase and program actions
`timescale 1ns/1ps
`include "nvm_defs.svh"

module eeprom_array #(
    parameter int WORDS = `NVM_WORDS,
    parameter int WIDTH = `NVM_WIDTH,
    parameter int AW    = $clog2(WORDS)
) (
    // clock, reset and enable
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    // actions as one-cycle strobes, then program mode, address and data
    input  wire logic             bulk_erase_i,
    input  wire logic             word_erase_i,
    input  wire logic             program_i,
    input  wire logic             and_mode_i,
    input  wire logic [AW-1:0]    addr_i,
    input  wire logic [WIDTH-1:0] data_i,
    // read port
    input  wire logic [AW-1:0]    rd_addr_i,
    output logic      [WIDTH-1:0] rd_data_o
);

    // ============================================================
    // storage
    logic [WIDTH-1:0] mem_q [WORDS];
    logic [WIDTH-1:0] mem_d [WORDS];

    genvar gi;
    generate
        for (gi = 0; gi < WORDS; gi++)
        begin : g_word
            always_comb
            begin
                mem_d[gi] = mem_q[gi];
                if (bulk_erase_i)
                begin
                    // whole array, address ignored
                    mem_d[gi] = WIDTH'(`NVM_ERASED);
                end
                else if (addr_i == AW'(gi))
                begin
                    if (word_erase_i)
                    begin
                        mem_d[gi] = WIDTH'(`NVM_ERASED);
                    end
                    else if (program_i)
                    begin
                        // without erase, cells can only clear
                        mem_d[gi] = and_mode_i ? (mem_q[gi] & data_i)
                                               : data_i;
                    end
                end
            end

            always_ff @(posedge clock_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    mem_q[gi] <= WIDTH'(`NVM_ERASED);
                end
                else if (ce_i)
                begin
                    mem_q[gi] <= mem_d[gi];
                end
            end
        end
    endgenerate

    assign rd_data_o = mem_q[rd_addr_i];

    // ============================================================
    // checks
    chk_bulk_all_erased: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && bulk_erase_i |=> mem_q[0] == WIDTH'(`NVM_ERASED)
            && mem_q[WORDS-1] == WIDTH'(`NVM_ERASED))
        else $error("bulk erase left words unerased");

    chk_prog_writes_latch: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && program_i && !bulk_erase_i && !word_erase_i && !and_mode_i
        |=> mem_q[$past(addr_i)] == $past(data_i))
        else $error("program did not store latch word");

endmodule : eeprom_array

// >>> verilog/data_eeprom_unlock_program.sv
// data eeprom unlock, control and program sequencer on axi4-lite
//
// Summary of operation
// - the key register is write-only and only guards against stray operations
// - only a 55h write followed by an AAh write to the key unlocks
// - after unlock only the next bus write may set the go bit
// - setting go inside the window starts the configured operation
// - bulk erase clears the whole array regardless of the address register
// - on completion go clears and the done flag sets
// - with program-without-erase set, programming only clears bits
// - word program stores the write latch into the addressed word
// - low six control bits 0001xx select a word program unless bits 12:0 equal 0004h
// - control value 4050h selects bulk erase
// - control value 4004h selects single word erase
// - the bus keeps answering while an operation runs
// - the array is 256 words of 16 bits
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "nvm_defs.svh"

module data_eeprom_unlock_program #(
    parameter int unsigned OP_CYCLES = `NVM_OP_CYCLES,
    parameter int          ADDR_W    = 8
) (
    // clock, reset, enable
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    // axi4-lite write address and data
    input  wire logic [ADDR_W-1:0] awaddr_i,
    input  wire logic              awvalid_i,
    output logic                   awready_o,
    input  wire logic [31:0]       wdata_i,
    input  wire logic [3:0]        wstrb_i,
    input  wire logic              wvalid_i,
    output logic                   wready_o,
    // axi4-lite write response
    output logic      [1:0]        bresp_o,
    output logic                   bvalid_o,
    input  wire logic              bready_i,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] araddr_i,
    input  wire logic              arvalid_i,
    output logic                   arready_o,
    output logic      [31:0]       rdata_o,
    output logic      [1:0]        rresp_o,
    output logic                   rvalid_o,
    input  wire logic              rready_i
);

    // ============================================================
    // bus slave
    logic              aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
    logic [ADDR_W-1:0] waddr_q, waddr_d;
    logic [15:0]       wdata_q, wdata_d;
    logic [1:0]        wstrb_q, wstrb_d;
    logic              awready_q, awready_d, wready_q, wready_d;
    logic              bvalid_q, bvalid_d, arready_q, arready_d;
    logic              rvalid_q, rvalid_d, rd_key_q, rd_key_d;
    logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0]       rdata_q, rdata_d;
    logic              wr_fire, wr_mapped;
    logic [15:0]       wmask;

    // registers and sequencers
    nvm_pkg::unlock_state_t ul_q, ul_d;
    nvm_pkg::op_state_t     op_q, op_d;
    nvm_pkg::op_kind_t      kind_q, kind_d, new_kind;
    logic [15:0]            ctrl_q, ctrl_d, ctrl_rd, ctrl_new;
    logic                   go_q, go_d, done_q, done_d;
    logic [7:0]             addr_q, addr_d;
    logic [15:0]            latch_q, latch_d, mem_rd;
    logic [15:0]            cnt_q, cnt_d;
    logic                   key55, keyaa, ctrl_wr, start, finish, done_clr;

    function automatic nvm_pkg::op_kind_t decode_kind(input logic [15:0] v);
        if (v[5:0] == `NVM_OPSEL_BULK)
            decode_kind = nvm_pkg::KIND_BULK;
        else if (v[12:0] == `NVM_CTRL_WERASE)
            decode_kind = nvm_pkg::KIND_WERASE;
        else if (v[5:2] == `NVM_OPSEL_PROG)
            decode_kind = nvm_pkg::KIND_PROG;
        else
            decode_kind = nvm_pkg::KIND_NONE;
    endfunction : decode_kind

    assign wr_fire  = ce_i && aw_hold_q && w_hold_q && !bvalid_q;
    assign wmask    = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign wr_mapped = waddr_q == ADDR_W'(`NVM_KEY_OFS)
                    || waddr_q == ADDR_W'(`NVM_CTRL_OFS)
                    || waddr_q == ADDR_W'(`NVM_ADDR_OFS)
                    || waddr_q == ADDR_W'(`NVM_LATCH_OFS)
                    || waddr_q == ADDR_W'(`NVM_STATUS_OFS)
                    || waddr_q == ADDR_W'(`NVM_RDATA_OFS);

    always_comb
    begin
        aw_hold_d = aw_hold_q;
        waddr_d   = waddr_q;
        w_hold_d  = w_hold_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        arready_d = arready_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        rd_key_d  = rd_key_q;
        if (awvalid_i && awready_q)
        begin
            aw_hold_d = 1'b1;
            waddr_d   = awaddr_i;
        end
        if (wvalid_i && wready_q)
        begin
            w_hold_d = 1'b1;
            wdata_d  = wdata_i[15:0];
            wstrb_d  = wstrb_i[1:0];
        end
        if (bvalid_q && bready_i)
            bvalid_d = 1'b0;
        if (wr_fire)
        begin
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = wr_mapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end
        if (rvalid_q && rready_i)
            rvalid_d = 1'b0;
        if (arvalid_i && arready_q)
        begin
            // reads are served even while busy
            rvalid_d = 1'b1;
            rresp_d  = `AXI_RESP_OKAY;
            rd_key_d = araddr_i == ADDR_W'(`NVM_KEY_OFS);
            case (araddr_i)
                ADDR_W'(`NVM_KEY_OFS):    rdata_d = 32'h0000_0000;
                ADDR_W'(`NVM_CTRL_OFS):   rdata_d = {16'h0000, ctrl_rd};
                ADDR_W'(`NVM_ADDR_OFS):   rdata_d = {24'h00_0000, addr_q};
                ADDR_W'(`NVM_LATCH_OFS):  rdata_d = {16'h0000, latch_q};
                ADDR_W'(`NVM_STATUS_OFS): rdata_d = {30'h0000_0000,
                    op_q == nvm_pkg::OP_BUSY, done_q};
                ADDR_W'(`NVM_RDATA_OFS):  rdata_d = {16'h0000, mem_rd};
                default:
                begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = `AXI_RESP_SLVERR;
                end
            endcase
        end
        awready_d = !aw_hold_d;
        wready_d  = !w_hold_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            aw_hold_q <= 1'b0;
            waddr_q   <= '0;
            w_hold_q  <= 1'b0;
            wdata_q   <= 16'h0000;
            wstrb_q   <= 2'b00;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'b00;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= 2'b00;
            rd_key_q  <= 1'b0;
        end
        else if (ce_i)
        begin
            aw_hold_q <= aw_hold_d;
            waddr_q   <= waddr_d;
            w_hold_q  <= w_hold_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
            rd_key_q  <= rd_key_d;
        end
    end

    assign awready_o = awready_q;
    assign wready_o  = wready_q;
    assign bvalid_o  = bvalid_q;
    assign bresp_o   = bresp_q;
    assign arready_o = arready_q;
    assign rvalid_o  = rvalid_q;
    assign rdata_o   = rdata_q;
    assign rresp_o   = rresp_q;

    // ============================================================
    // unlock detector and operation sequencer
    // a whole-byte key write is needed; a partial strobe counts as stray
    assign key55 = wr_fire && waddr_q == ADDR_W'(`NVM_KEY_OFS) && wstrb_q[0]
                && wdata_q[7:0] == `NVM_KEY_FIRST;
    assign keyaa = wr_fire && waddr_q == ADDR_W'(`NVM_KEY_OFS) && wstrb_q[0]
                && wdata_q[7:0] == `NVM_KEY_SECOND;
    assign ctrl_wr  = wr_fire && waddr_q == ADDR_W'(`NVM_CTRL_OFS);
    assign ctrl_rd  = {go_q, ctrl_q[14:0]};
    assign ctrl_new = (ctrl_rd & ~wmask) | (wdata_q & wmask);
    assign new_kind = decode_kind(ctrl_new);
    assign start    = ctrl_wr && ul_q == nvm_pkg::UL_OPEN
                   && op_q == nvm_pkg::OP_IDLE
                   && ctrl_new[`NVM_CTRL_GO_BIT]
                   && ctrl_new[`NVM_CTRL_WREN_BIT]
                   && new_kind != nvm_pkg::KIND_NONE;
    assign finish   = ce_i && op_q == nvm_pkg::OP_BUSY && cnt_q == 16'h0001;
    assign done_clr = wr_fire && waddr_q == ADDR_W'(`NVM_STATUS_OFS)
                   && wstrb_q[0] && wdata_q[`NVM_STAT_DONE_BIT];

    always_comb
    begin
        ul_d    = ul_q;
        op_d    = op_q;
        kind_d  = kind_q;
        ctrl_d  = ctrl_q;
        go_d    = go_q;
        done_d  = done_q;
        addr_d  = addr_q;
        latch_d = latch_q;
        cnt_d   = cnt_q;
        if (wr_fire)
        begin
            case (ul_q)
                nvm_pkg::UL_IDLE:  ul_d = key55 ? nvm_pkg::UL_GOT55
                                                : nvm_pkg::UL_IDLE;
                nvm_pkg::UL_GOT55: ul_d = keyaa ? nvm_pkg::UL_OPEN
                                                : nvm_pkg::UL_IDLE;
                nvm_pkg::UL_OPEN:  ul_d = nvm_pkg::UL_IDLE;
                default:           ul_d = nvm_pkg::UL_IDLE;
            endcase
        end
        // configuration is frozen while an operation runs
        if (ctrl_wr && op_q == nvm_pkg::OP_IDLE)
            ctrl_d = ctrl_new & `NVM_CTRL_WMASK;
        if (op_q == nvm_pkg::OP_IDLE && wr_fire)
        begin
            if (waddr_q == ADDR_W'(`NVM_ADDR_OFS))
                addr_d = (addr_q & ~wmask[7:0]) | (wdata_q[7:0] & wmask[7:0]);
            if (waddr_q == ADDR_W'(`NVM_LATCH_OFS))
                latch_d = (latch_q & ~wmask) | (wdata_q & wmask);
        end
        if (done_clr)
            done_d = 1'b0;
        case (op_q)
            nvm_pkg::OP_IDLE:
            begin
                if (start)
                begin
                    op_d   = nvm_pkg::OP_BUSY;
                    go_d   = 1'b1;
                    kind_d = new_kind;
                    cnt_d  = OP_CYCLES[15:0];
                end
            end
            nvm_pkg::OP_BUSY:
            begin
                cnt_d = cnt_q - 16'h0001;
                if (cnt_q == 16'h0001)
                begin
                    op_d   = nvm_pkg::OP_IDLE;
                    go_d   = 1'b0;
                    done_d = 1'b1; // set wins over clear
                end
            end
            default: op_d = nvm_pkg::OP_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ul_q    <= nvm_pkg::UL_IDLE;
            op_q    <= nvm_pkg::OP_IDLE;
            kind_q  <= nvm_pkg::KIND_NONE;
            ctrl_q  <= `NVM_CTRL_RESET;
            go_q    <= 1'b0;
            done_q  <= 1'b0;
            addr_q  <= 8'h00;
            latch_q <= `NVM_ZERO16;
            cnt_q   <= 16'h0000;
        end
        else if (ce_i)
        begin
            ul_q    <= ul_d;
            op_q    <= op_d;
            kind_q  <= kind_d;
            ctrl_q  <= ctrl_d;
            go_q    <= go_d;
            done_q  <= done_d;
            addr_q  <= addr_d;
            latch_q <= latch_d;
            cnt_q   <= cnt_d;
        end
    end

    // ============================================================
    // storage, 256 x 16
    eeprom_array #(
        .WORDS (`NVM_WORDS),
        .WIDTH (`NVM_WIDTH)
    ) u_array (
        .clock_i      (clock_i),
        .rst_i        (rst_i),
        .ce_i         (ce_i),
        .bulk_erase_i (finish && kind_q == nvm_pkg::KIND_BULK),
        .word_erase_i (finish && kind_q == nvm_pkg::KIND_WERASE),
        .program_i    (finish && kind_q == nvm_pkg::KIND_PROG),
        .and_mode_i   (ctrl_q[`NVM_CTRL_PONLY_BIT]),
        .addr_i       (addr_q),
        .data_i       (latch_q),
        .rd_addr_i    (addr_q),
        .rd_data_o    (mem_rd)
    );

    // ============================================================
    // checks
    chk_key_reads_zero: assert property (
        @(posedge clock_i) disable iff (rst_i)
        rvalid_q && rd_key_q |-> rdata_q == 32'h0000_0000)
        else $error("key register read back nonzero");

    chk_unlock_order: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ul_q == nvm_pkg::UL_OPEN && $past(ul_q) != nvm_pkg::UL_OPEN
        |-> $past(ul_q) == nvm_pkg::UL_GOT55 && $past(keyaa))
        else $error("window opened without ordered key pair");

    chk_window_single: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ul_q == nvm_pkg::UL_OPEN && wr_fire |=> ul_q == nvm_pkg::UL_IDLE)
        else $error("window outlived one write");

    chk_go_needs_window: assert property (
        @(posedge clock_i) disable iff (rst_i)
        $rose(go_q) |-> $past(ul_q) == nvm_pkg::UL_OPEN && $past(ctrl_wr))
        else $error("go set outside unlock window");

    chk_go_starts_op: assert property (
        @(posedge clock_i) disable iff (rst_i)
        start |=> op_q == nvm_pkg::OP_BUSY && go_q
            && cnt_q == OP_CYCLES[15:0])
        else $error("go in window did not start operation");

    chk_done_on_finish: assert property (
        @(posedge clock_i) disable iff (rst_i)
        finish |=> !go_q && done_q && op_q == nvm_pkg::OP_IDLE)
        else $error("completion did not clear go and set done");

    chk_done_set_wins: assert property (
        @(posedge clock_i) disable iff (rst_i)
        finish && done_clr |=> done_q)
        else $error("done clear beat a coincident set");

    chk_read_while_busy: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ce_i && op_q == nvm_pkg::OP_BUSY && arvalid_i && arready_q
        |=> rvalid_q)
        else $error("read stalled during operation");

    chk_stray_write_idle: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ul_q == nvm_pkg::UL_GOT55 && wr_fire && !keyaa
        |=> ul_q == nvm_pkg::UL_IDLE)
        else $error("stray write did not reset unlock detector");

endmodule : data_eeprom_unlock_program

// >>> sim/tb.sv
// self-checking bench for the data eeprom unlock and program block
`timescale 1ns/1ps
`include "nvm_defs.svh"

module tb;
    // ============================================================
    // signals
    logic        clock_i = 0, rst_i = 1, ce_i = 1;
    logic [7:0]  awaddr_i = 0, araddr_i = 0;
    logic [31:0] wdata_i = 0, rdata_o;
    logic [3:0]  wstrb_i = 4'hF;
    logic        awvalid_i = 0, wvalid_i = 0, bready_i = 1;
    logic        arvalid_i = 0, rready_i = 1;
    logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
    logic [1:0]  bresp_o, rresp_o;
    logic [33:0] q[$];
    logic [1:0]  bq[$];
    logic [33:0] e;
    logic [15:0] d, m;
    int          miscompares = 0, tests_run = 0, cyc = 0;

    data_eeprom_unlock_program #(.OP_CYCLES(16)) i_dut (.*);

    initial forever #4 clock_i = ~clock_i;

    // ============================================================
    // checks and bus tasks
    task automatic chk(input logic [33:0] s, input logic [33:0] x);
        tests_run++;
        if (s !== x)
        begin
            miscompares++;
            $display("BAD %0t read %h want %h", $time, s, x);
        end
    endtask : chk

    task automatic close_out();
        if (miscompares == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    // bready held high, so a b answer is taken at once
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bq.push_back((a <= `NVM_RDATA_OFS && a[1:0] == 2'b00)
                     ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR);
        awaddr_i  <= a;
        wdata_i   <= v;
        awvalid_i <= 1'b1;
        wvalid_i  <= 1'b1;
        forever
        begin
            @(posedge clock_i);
            if (awvalid_i && awready_o === 1'b1) awvalid_i <= 1'b0;
            if (wvalid_i && wready_o === 1'b1) wvalid_i <= 1'b0;
            if (bvalid_o === 1'b1) break;
        end
    endtask : wr

    // expected answer is noted, the monitor compares it
    task automatic rd(input logic [7:0] a, input logic [33:0] x);
        q.push_back(x);
        araddr_i  <= a;
        arvalid_i <= 1'b1;
        do @(posedge clock_i); while (arready_o !== 1'b1);
        arvalid_i <= 1'b0;
        do @(posedge clock_i); while (rvalid_o !== 1'b1);
    endtask : rd

    // configure, unlock, go; check busy, then done and go cleared
    task automatic run(input logic [15:0] c);
        wr(`NVM_STATUS_OFS, 32'h1);
        wr(`NVM_CTRL_OFS, {16'h0, c});
        wr(`NVM_KEY_OFS, 32'h55);
        wr(`NVM_KEY_OFS, 32'hAA);
        wr(`NVM_CTRL_OFS, {16'h0, c | 16'h8000});
        rd(`NVM_STATUS_OFS, 34'h2);
        repeat (40) @(posedge clock_i);
        rd(`NVM_STATUS_OFS, 34'h1);
        rd(`NVM_CTRL_OFS, {18'h0, c});
    endtask : run

    always @(posedge clock_i)
    begin
        if (rvalid_o === 1'b1 && rready_i)
        begin
            e = q.pop_front();
            chk({rresp_o, rdata_o}, e);
        end
        if (bvalid_o === 1'b1 && bready_i)
            chk({32'h0, bresp_o}, {32'h0, bq.pop_front()});
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            close_out();
        end
    end

    // ============================================================
    // scenarios
    logic [7:0] k1[4] = '{8'hAA, 8'h55, 8'h55, 8'h55};
    logic [7:0] k2[4] = '{8'h55, 8'h55, 8'hAA, 8'hAA};

    initial
    begin
        void'($urandom(32'hD8DCF57E));
        d = 16'($urandom);
        m = 16'($urandom);
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        rd(`NVM_KEY_OFS, 34'h0);
        rd(8'h20, {`AXI_RESP_SLVERR, 32'h0});
        wr(8'h20, 32'h0);
        wr(`NVM_ADDR_OFS, 32'h3);
        wr(`NVM_LATCH_OFS, {16'h0, d});
        run(16'h4005);
        rd(`NVM_RDATA_OFS, {18'h0, d});
        // bad preambles: wrong order, double first key, stray
        // write between keys, stray write inside the window
        wr(`NVM_STATUS_OFS, 32'h1);
        wr(`NVM_LATCH_OFS, {16'h0, ~d});
        for (int i = 0; i < 4; i++)
        begin
            wr(`NVM_KEY_OFS, {24'h0, k1[i]});
            if (i == 2) wr(`NVM_ADDR_OFS, 32'h3);
            wr(`NVM_KEY_OFS, {24'h0, k2[i]});
            if (i == 3) wr(`NVM_ADDR_OFS, 32'h3);
            wr(`NVM_CTRL_OFS, 32'hC005);
            rd(`NVM_STATUS_OFS, 34'h0);
        end
        wr(`NVM_CTRL_OFS, 32'hC005);
        rd(`NVM_STATUS_OFS, 34'h0);
        rd(`NVM_RDATA_OFS, {18'h0, d});
        // program without erase only clears bits
        wr(`NVM_LATCH_OFS, {16'h0, m});
        run(16'h5005);
        rd(`NVM_RDATA_OFS, {18'h0, d & m});
        run(16'h4004);
        rd(`NVM_RDATA_OFS, {18'h0, `NVM_ERASED});
        wr(`NVM_LATCH_OFS, {16'h0, d});
        run(16'h4005);
        wr(`NVM_ADDR_OFS, 32'h9);
        run(16'h4050);
        wr(`NVM_ADDR_OFS, 32'h3);
        rd(`NVM_RDATA_OFS, {18'h0, `NVM_ERASED});
        wr(`NVM_ADDR_OFS, 32'hFF);
        rd(`NVM_RDATA_OFS, {18'h0, `NVM_ERASED});
        // a low enable must freeze the running count
        wr(`NVM_KEY_OFS, 32'h55);
        wr(`NVM_KEY_OFS, 32'hAA);
        wr(`NVM_CTRL_OFS, 32'hC050);
        ce_i <= 1'b0;
        repeat (40) @(posedge clock_i);
        ce_i <= 1'b1;
        rd(`NVM_STATUS_OFS, 34'h3);
        repeat (40) @(posedge clock_i);
        rd(`NVM_STATUS_OFS, 34'h1);
        repeat (4) @(posedge clock_i);
        close_out();
    end
endmodule : tb
